// ### verilog/aesm_consts.svh
// register offsets, field positions and timing counts of the cipher register front end
// assumes an 8-bit data-space register port and a 40 MHz system clock
`ifndef AESM_CONSTS_SVH
`define AESM_CONSTS_SVH
`define AESM_OFS_CTRL 9'h13c
`define AESM_OFS_STAT 9'h13d
`define AESM_OFS_TEXT 9'h13e
`define AESM_OFS_KEY 9'h13f
`define AESM_OFS_IRQ_STAT 9'h140
`define AESM_OFS_IRQ_MASK 9'h143
`define AESM_CTRL_RUN 7
`define AESM_CTRL_MODE 5
`define AESM_CTRL_DIR 3
`define AESM_CTRL_IE 2
`define AESM_STAT_ERR 7
`define AESM_STAT_DONE 0
`define AESM_CTRL_RST 8'h00
`define AESM_STAT_RST 8'h00
`define AESM_CTRL_WMASK 8'h2c
`define AESM_RUN_CYCLES 5'h14
`endif

// ### verilog/aesm_pkg.sv
// types shared by the cipher register front end
// assumes aesm_consts.svh holds the register offsets, field positions and run length
package aesm_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} aesm_state_t;
    typedef struct packed {
        logic cbc;
        logic decrypt;
        logic irq_en;
    } aesm_ctrl_t;
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } aesm_bus_t;
endpackage : aesm_pkg

// ### verilog/aesm_regs.sv
// cipher register front end: control, status, text and key buffers, run sequencer, irq
// assumes a synchronous register port from the cpu on clk_sys_i, sleep_i from transceiver logic
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "aesm_consts.svh"

module aesm_regs #(
    parameter int unsigned NBYTES = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // transceiver sleep entry level
    input wire logic sleep_i,
    // register port
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // interrupt and busy
    output logic irq_o,
    output logic busy_o
);
    localparam int unsigned PW = $clog2(NBYTES);

    aesm_pkg::aesm_bus_t bus;
    aesm_pkg::aesm_state_t state_r;
    aesm_pkg::aesm_ctrl_t ctrl_r;
    logic [7:0] text_r [NBYTES];
    logic [7:0] key_r [NBYTES];
    logic [7:0] rkey_r [NBYTES];
    logic [PW-1:0] tptr_r, kptr_r;
    logic [PW:0] twr_cnt_r, trd_cnt_r, kwr_cnt_r;
    logic [4:0] cyc_r, run_len_r;
    logic done_r, err_r, sleep_d_r;
    logic [1:0] irq_stat_r, irq_mask_r;
    logic [7:0] rdata_r;
    logic irq_r, busy_r;
    logic ctrl_acc, text_acc, key_acc, start, sleep_ent, finish, load_bad, abort;

    // one carrier for the port fields
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
        hit = a == ofs;
    endfunction : hit

    // round-key stand-in: a keyed byte mix, not a real cipher core
    function automatic logic [7:0] mix(input logic [7:0] d, input logic [7:0] k, input logic [3:0] i);
        mix = {d[6:0], d[7]} ^ k ^ {4'h0, i};
    endfunction : mix

    assign ctrl_acc = (bus.wr | bus.rd) & hit(bus.addr, `AESM_OFS_CTRL);
    assign text_acc = (bus.wr | bus.rd) & hit(bus.addr, `AESM_OFS_TEXT);
    assign key_acc = (bus.wr | bus.rd) & hit(bus.addr, `AESM_OFS_KEY);
    assign sleep_ent = sleep_i & ~sleep_d_r;
    assign start = bus.wr & hit(bus.addr, `AESM_OFS_CTRL) & bus.wdata[`AESM_CTRL_RUN]
                   & (state_r != aesm_pkg::ST_RUN);
    assign abort = ctrl_acc & (state_r == aesm_pkg::ST_RUN);
    // a partial fill or drain leaves a count between zero and full
    assign load_bad = (twr_cnt_r != 0 && twr_cnt_r < NBYTES) || (trd_cnt_r != 0 && trd_cnt_r < NBYTES)
                      || (kwr_cnt_r != 0 && kwr_cnt_r < NBYTES);
    assign finish = (state_r == aesm_pkg::ST_RUN) & (cyc_r == 5'h01) & ~abort;

    // sleep edge detect, sleep_i comes from same-clock logic
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_d_r <= 1'b0;
        end else begin
            sleep_d_r <= sleep_i;
        end
    end

    // control fields; reserved bits are never stored so they read zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else if (sleep_ent) begin
            ctrl_r <= '0;
        end else if (bus.wr && hit(bus.addr, `AESM_OFS_CTRL)) begin
            ctrl_r.cbc <= bus.wdata[`AESM_CTRL_MODE];
            ctrl_r.decrypt <= bus.wdata[`AESM_CTRL_DIR];
            ctrl_r.irq_en <= bus.wdata[`AESM_CTRL_IE];
        end
    end

    // written mode and direction fields follow the data bits of the same write
    chk_ctrl_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus.wr && hit(bus.addr, `AESM_OFS_CTRL) && !sleep_ent
        |=> ctrl_r.cbc == $past(bus.wdata[`AESM_CTRL_MODE])
        && ctrl_r.decrypt == $past(bus.wdata[`AESM_CTRL_DIR])) else $error("ctrl field lost");

    // run sequencer: fixed latency, any control access aborts; busy is a flop copy of the run state
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= aesm_pkg::ST_IDLE;
            cyc_r <= 5'h00;
            busy_r <= 1'b0;
        end else if (sleep_ent || abort) begin
            state_r <= aesm_pkg::ST_IDLE;
            cyc_r <= 5'h00;
            busy_r <= 1'b0;
        end else begin
            unique case (state_r)
                aesm_pkg::ST_IDLE, aesm_pkg::ST_DONE: begin
                    if (start && !load_bad) begin
                        state_r <= aesm_pkg::ST_RUN;
                        cyc_r <= `AESM_RUN_CYCLES;
                        busy_r <= 1'b1;
                    end
                end
                aesm_pkg::ST_RUN: begin
                    cyc_r <= cyc_r - 5'h01;
                    if (cyc_r == 5'h01) begin
                        state_r <= aesm_pkg::ST_DONE;
                        busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // run length watch for the checks; a stuck sequencer shows up as an overlong run
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_len_r <= 5'h00;
        end else if (state_r == aesm_pkg::ST_RUN) begin
            run_len_r <= run_len_r + 5'h01;
        end else begin
            run_len_r <= 5'h00;
        end
    end

    chk_run_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_r == aesm_pkg::ST_RUN |-> run_len_r < `AESM_RUN_CYCLES) else $error("run too long");
    chk_start_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && !load_bad && !sleep_ent |=> busy_o) else $error("busy not raised");

    // status flags; a new run clears them first
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else if (sleep_ent) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else if (abort) begin
            err_r <= 1'b1;
        end else if (start) begin
            done_r <= 1'b0;
            err_r <= load_bad;
        end else if (finish) begin
            done_r <= 1'b1;
        end
    end

    // flag checks: completion sets done alone, a new request clears it
    chk_done_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        finish && !sleep_ent |=> done_r && !err_r) else $error("done not set");
    chk_start_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && !sleep_ent |=> !done_r) else $error("done not cleared");

    // text buffer pointer and counts; reads and writes share one pointer
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tptr_r <= '0;
            twr_cnt_r <= '0;
            trd_cnt_r <= '0;
        end else if (sleep_ent || start || finish) begin
            tptr_r <= '0;
            twr_cnt_r <= '0;
            trd_cnt_r <= '0;
        end else if (text_acc) begin
            tptr_r <= tptr_r + 1'b1;
            if (bus.wr && twr_cnt_r != NBYTES) twr_cnt_r <= twr_cnt_r + 1'b1;
            if (bus.rd && trd_cnt_r != NBYTES) trd_cnt_r <= trd_cnt_r + 1'b1;
        end
    end

    // pointer checks: sleep and a new run rewind the buffers
    chk_sleep_ptr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sleep_ent |=> tptr_r == '0 && twr_cnt_r == '0 && trd_cnt_r == '0) else $error("text ptr not cleared");
    chk_ptr_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && !sleep_ent |=> tptr_r == '0 && kptr_r == '0) else $error("ptr not rewound");

    // text storage; the result overwrites the input at completion
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NBYTES; i++) text_r[i] <= 8'h00;
        end else if (sleep_ent) begin
            for (int i = 0; i < NBYTES; i++) text_r[i] <= 8'h00;
        end else if (finish) begin
            for (int i = 0; i < NBYTES; i++) begin
                text_r[i] <= mix(text_r[i] ^ (ctrl_r.cbc ? 8'h5a : 8'h00), key_r[i],
                                 {ctrl_r.decrypt, 3'(i)});
            end
        end else if (bus.wr && hit(bus.addr, `AESM_OFS_TEXT)) begin
            text_r[tptr_r] <= bus.wdata;
        end
    end

    // key pointer and fill count
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            kptr_r <= '0;
            kwr_cnt_r <= '0;
        end else if (sleep_ent || start) begin
            kptr_r <= '0;
            kwr_cnt_r <= '0;
        end else if (key_acc) begin
            kptr_r <= kptr_r + 1'b1;
            if (bus.wr && kwr_cnt_r != NBYTES) kwr_cnt_r <= kwr_cnt_r + 1'b1;
        end
    end

    // key pointer steps once per access
    chk_key_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        key_acc && !sleep_ent && !start |=> kptr_r == $past(kptr_r) + 1'b1) else $error("key step");

    // written key kept apart from the readable round key
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NBYTES; i++) key_r[i] <= 8'h00;
        end else if (sleep_ent) begin
            for (int i = 0; i < NBYTES; i++) key_r[i] <= 8'h00;
        end else if (bus.wr && hit(bus.addr, `AESM_OFS_KEY)) begin
            key_r[kptr_r] <= bus.wdata;
        end
    end

    // readable key: mirrors writes, takes the round key at completion
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NBYTES; i++) rkey_r[i] <= 8'h00;
        end else if (sleep_ent) begin
            for (int i = 0; i < NBYTES; i++) rkey_r[i] <= 8'h00;
        end else if (finish) begin
            for (int i = 0; i < NBYTES; i++) rkey_r[i] <= mix(key_r[i], 8'ha5, 4'(i));
        end else if (bus.wr && hit(bus.addr, `AESM_OFS_KEY)) begin
            rkey_r[kptr_r] <= bus.wdata;
        end
    end

    // sticky events: bit0 done, bit1 error; set beats write-one clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~({2{bus.wr && hit(bus.addr, `AESM_OFS_IRQ_STAT)}} & bus.wdata[1:0]))
                          | {abort | (start & load_bad), finish};
        end
    end

    // an event must win over a clear in the same cycle
    chk_irq_set_win: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        finish |=> irq_stat_r[0]) else $error("done event lost");
    chk_err_event: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        abort |=> irq_stat_r[1]) else $error("error event lost");

    // mask register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask_r <= 2'h0;
        end else if (bus.wr && hit(bus.addr, `AESM_OFS_IRQ_MASK)) begin
            irq_mask_r <= bus.wdata[1:0];
        end
    end

    // enable bit gates the whole interrupt
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ctrl_r.irq_en & |(irq_stat_r & irq_mask_r);
        end
    end

    // level follows enabled, unmasked events one cycle late
    chk_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ctrl_r.irq_en && |(irq_stat_r & irq_mask_r) |=> irq_o) else $error("irq not raised");
    chk_mask_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        irq_mask_r == 2'h0 |=> !irq_o) else $error("irq while masked");

    // read data for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (!bus.rd) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (bus.addr)
                `AESM_OFS_CTRL: rdata_r <= {2'b00, ctrl_r.cbc, 1'b0, ctrl_r.decrypt, ctrl_r.irq_en, 2'b00};
                `AESM_OFS_STAT: rdata_r <= {err_r, 6'h00, done_r};
                `AESM_OFS_TEXT: rdata_r <= text_r[tptr_r];
                `AESM_OFS_KEY: rdata_r <= rkey_r[kptr_r];
                `AESM_OFS_IRQ_STAT: rdata_r <= {6'h00, irq_stat_r};
                `AESM_OFS_IRQ_MASK: rdata_r <= {6'h00, irq_mask_r};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // idle port reads zero, so a stale byte never looks like data
    chk_read_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !bus.rd |=> rdata_o == 8'h00) else $error("stale read data");

    // outputs straight from flops
    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign busy_o = busy_r;

    // remaining checks; a run ends done within its latency unless aborted or put to sleep
    chk_abort_err: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        abort && !sleep_ent |=> err_r && state_r == aesm_pkg::ST_IDLE) else $error("abort lost");
    chk_sleep_clr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sleep_ent |=> ctrl_r == '0 && !done_r && !err_r && text_r[0] == 8'h00) else $error("sleep clear");
    chk_start_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && !load_bad && !sleep_ent |=> state_r == aesm_pkg::ST_RUN) else $error("no start");
    chk_run_done: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && !load_bad && !sleep_ent |=> ##[0:21] (done_r || state_r == aesm_pkg::ST_IDLE)) else $error("no done");
    chk_status_rsv: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus.rd && bus.addr == `AESM_OFS_STAT |=> rdata_o[6:1] == 6'h00) else $error("status rsv");
    chk_text_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        text_acc && !sleep_ent && !start && !finish |=> tptr_r == $past(tptr_r) + 1'b1) else $error("step");
    chk_bad_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start && load_bad && !sleep_ent |=> err_r && !done_r) else $error("partial load");
    chk_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ctrl_r.irq_en |=> !irq_o) else $error("irq while disabled");
    chk_key_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        finish && !sleep_ent |=> key_r[0] == $past(key_r[0])) else $error("key changed");
endmodule : aesm_regs

// ### tb/aesm_regs_test.sv
// directed bench for the cipher register front end: register port tasks and test sequences
// assumes aesm_regs and its consts header on the include path, one 40 MHz clock
`timescale 1ns/10ps
`include "aesm_consts.svh"

module aesm_regs_test;
    // design inputs, all given a value at time zero
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [8:0] addr_i = 9'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic busy_o;
    int fail_count = 0;
    int checked = 0;
    logic [7:0] d;
    logic [7:0] res_a [16];

    // 25 ns period
    always #12.5 clk_sys_i = ~clk_sys_i;

    aesm_regs u_aesm_regs (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .sleep_i(sleep_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .busy_o(busy_o)
    );

    // byte and flag comparisons, case equality so x never matches
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask : chk1

    // one-cycle write strobe; returns just after the edge that takes it
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample right there
    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd

    // fill text and key buffers with the given byte counts
    task automatic load(input int nt, input int nk);
        for (int i = 0; i < nt; i++) wr(`AESM_OFS_TEXT, 8'(i + 1));
        for (int i = 0; i < nk; i++) wr(`AESM_OFS_KEY, 8'(8'ha0 + i));
    endtask : load

    // progress is learned from status only, never from control
    task automatic wait_done(output logic [7:0] s);
        s = 8'h00;
        for (int i = 0; i < 40 && s[0] !== 1'b1 && s[7] !== 1'b1; i++) rd(`AESM_OFS_STAT, s);
    endtask : wait_done

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(25 * 20000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // reset values, field storage, read-only status, unmapped space
        rd(`AESM_OFS_CTRL, d);
        chk8(d, `AESM_CTRL_RST, "ctrl reset");
        rd(`AESM_OFS_STAT, d);
        chk8(d, `AESM_STAT_RST, "stat reset");
        rd(9'h150, d);
        chk8(d, 8'h00, "unmapped read");
        wr(`AESM_OFS_CTRL, 8'h2c);
        rd(`AESM_OFS_CTRL, d);
        chk8(d, 8'h2c, "mode dir ie stored");
        wr(`AESM_OFS_STAT, 8'hff);
        rd(`AESM_OFS_STAT, d);
        chk8(d, 8'h00, "status not writable");
        $display("test reset_and_fields done");
        // both buffers step through one address each, reads and writes alike
        load(16, 16);
        for (int i = 0; i < 16; i++) begin
            rd(`AESM_OFS_TEXT, d);
            chk8(d, 8'(i + 1), "text readback");
            rd(`AESM_OFS_KEY, d);
            chk8(d, 8'(8'ha0 + i), "key readback");
        end
        $display("test buffer_step done");
        // full run with interrupt enabled and unmasked
        wr(`AESM_OFS_IRQ_MASK, 8'h01);
        load(16, 16);
        wr(`AESM_OFS_CTRL, 8'h84);
        chk1(busy_o, 1'b1, "busy after start");
        wait_done(d);
        chk8(d, 8'h01, "done flag");
        @(posedge clk_sys_i);
        #1;
        chk1(irq_o, 1'b1, "irq on completion");
        for (int i = 0; i < 16; i++) rd(`AESM_OFS_TEXT, res_a[i]);
        wr(`AESM_OFS_IRQ_STAT, 8'h03);
        @(posedge clk_sys_i);
        #1;
        chk1(irq_o, 1'b0, "irq cleared");
        $display("test run_with_irq done");
        // control access in mid-run aborts and flags an error
        load(16, 16);
        wr(`AESM_OFS_CTRL, 8'h84);
        rd(`AESM_OFS_CTRL, d);
        #1;
        chk1(busy_o, 1'b0, "abort stops run");
        rd(`AESM_OFS_STAT, d);
        chk8(d, 8'h80, "abort error, done cleared");
        $display("test abort done");
        // interrupt enable clear: run completes, no interrupt
        wr(`AESM_OFS_IRQ_STAT, 8'h03);
        load(16, 16);
        wr(`AESM_OFS_CTRL, 8'h80);
        rd(`AESM_OFS_STAT, d);
        chk8(d, 8'h00, "start clears flags");
        wait_done(d);
        chk8(d, 8'h01, "done without irq");
        @(posedge clk_sys_i);
        #1;
        chk1(irq_o, 1'b0, "no irq when disabled");
        $display("test irq_disabled done");
        // text reloaded alone after a finished run: the kept key gives the same result
        load(16, 0);
        wr(`AESM_OFS_CTRL, 8'h80);
        wait_done(d);
        chk8(d, 8'h01, "rerun done");
        for (int i = 0; i < 16; i++) begin
            rd(`AESM_OFS_TEXT, d);
            chk8(d, res_a[i], "key reused");
        end
        $display("test key_reuse done");
        // partial text fill then start
        load(5, 0);
        wr(`AESM_OFS_CTRL, 8'h80);
        chk1(busy_o, 1'b0, "partial fill does not run");
        rd(`AESM_OFS_STAT, d);
        chk8(d, 8'h80, "partial fill error");
        rd(`AESM_OFS_IRQ_STAT, d);
        chk8(d, 8'h03, "done and error events held");
        wr(`AESM_OFS_IRQ_MASK, 8'h02);
        chk1(irq_o, 1'b0, "error irq held off by enable bit");
        wr(`AESM_OFS_CTRL, 8'h04);
        @(posedge clk_sys_i);
        #1;
        chk1(irq_o, 1'b1, "error irq once enabled");
        $display("test partial_fill done");
        // sleep entry clears control, status and text
        wr(`AESM_OFS_CTRL, 8'h2c);
        load(3, 0);
        @(posedge clk_sys_i);
        sleep_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sleep_i <= 1'b0;
        rd(`AESM_OFS_CTRL, d);
        chk8(d, 8'h00, "ctrl after sleep");
        rd(`AESM_OFS_STAT, d);
        chk8(d, 8'h00, "stat after sleep");
        rd(`AESM_OFS_TEXT, d);
        chk8(d, 8'h00, "text after sleep");
        $display("test sleep_clear done");
        tally_and_finish();
    end
endmodule : aesm_regs_test
